/* File: pkg/kbscan_pkg.sv */
// Constants for the keyboard scanning link device end.
// Assumes a 250 MHz system clock; the link clock is sampled, not used as a clock.
package kbscan_pkg;
  localparam int CLK_PERIOD_PS     = 4000;
  // Clear threshold: link low longer than this clears the counter
  localparam int CLEAR_TIME_NS     = 30000;
  // Advance limit: a low pulse shorter than this advances the counter
  localparam int ADVANCE_TIME_NS   = 6000;
  localparam int CLEAR_CYCLES      = (CLEAR_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int ADVANCE_CYCLES    = (ADVANCE_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Matrix geometry
  localparam int ROWS              = 8;
  localparam int COLS              = 16;
  localparam int KEYS              = ROWS * COLS;
  localparam int KEY_W             = 7;
  localparam int ROW_W             = 3;
  localparam int LOW_W             = 14;
  localparam logic [KEY_W-1:0] KEY_START = 7'h00;
  localparam logic [LOW_W-1:0] LOW_ZERO  = 14'h0000;
  localparam logic [LOW_W-1:0] LOW_ONE   = 14'h0001;
  // One key per short pulse; the counter wraps past the last key
  localparam logic [KEY_W-1:0] KEY_STEP  = 7'h01;
  // Idle level of the link clock, also its synchroniser's reset value
  localparam logic             LINK_IDLE = 1'b1;
  typedef enum logic [1:0] {KB_IDLE, KB_LOW, KB_CLEARED} kbscan_state_type;
endpackage

/* File: src/kbscan_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain.
// Assumes an asynchronous active-low reset already released in clk's domain.
// Each instance resets to the idle level of what it carries, so no false edge follows reset.
`timescale 1ns/100ps
module kbscan_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage <= RESET_VALUE;
      q     <= RESET_VALUE;
    end
    else
    begin
      stage <= d;
      q     <= stage;
    end
  end
endmodule // kbscan_sync

/* File: src/kbscan_link.sv */
// Key-scanning end of the keyboard link: counter driven by link clock pulse widths.
// Assumes the terminal drives link_clk idle high; key states are raw switch levels.
// Assumes clk at 250 MHz, since every width limit is a fixed count of its cycles.
`timescale 1ns/100ps
module kbscan_link (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Link from the terminal
  input  wire logic                         link_clk,
  output logic                              key_return,
  // Key matrix switch levels, high while pressed
  input  wire logic [kbscan_pkg::KEYS-1:0]  key_pressed,
  // Observation
  output logic [kbscan_pkg::KEY_W-1:0]      key_index
);
  // Reset release
  logic                             rst_sync1;
  logic                             rst_n;
  // Synchronised inputs and the edge memory
  logic                             link_s;
  logic                             link_prev;
  logic [kbscan_pkg::KEYS-1:0]      keys_s;
  // Pulse measurement
  logic [kbscan_pkg::LOW_W-1:0]     low_count;
  kbscan_pkg::kbscan_state_type     state;
  // Next-state values
  kbscan_pkg::kbscan_state_type     next_state;
  logic [kbscan_pkg::KEY_W-1:0]     next_index;
  logic [kbscan_pkg::LOW_W-1:0]     next_low;

  // Reset is asserted at once but released on clk, so no flop sees a runt release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync1 <= 1'b0;
      rst_n     <= 1'b0;
    end
    else
    begin
      rst_sync1 <= 1'b1;
      rst_n     <= rst_sync1;
    end
  end

  // The link idles high, so its synchroniser resets high too; a low reset value
  // would read as a falling edge straight after reset and step the counter.
  kbscan_sync #(
    .WIDTH       (1),
    .RESET_VALUE (kbscan_pkg::LINK_IDLE)
  ) u_link_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (link_clk),
    .q     (link_s)
  );

  // Switch contacts are asynchronous as well; released keys read low after reset
  kbscan_sync #(
    .WIDTH       (kbscan_pkg::KEYS),
    .RESET_VALUE ({kbscan_pkg::KEYS{1'b0}})
  ) u_key_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (key_pressed),
    .q     (keys_s)
  );

  // Edges of the synchronised link clock
  wire fall_edge  = link_prev & ~link_s;
  wire rise_edge  = ~link_prev & link_s;

  // Width classes of the low level measured so far
  wire clear_hit  = (low_count >= kbscan_pkg::LOW_W'(kbscan_pkg::CLEAR_CYCLES));
  wire short_low  = (low_count <  kbscan_pkg::LOW_W'(kbscan_pkg::ADVANCE_CYCLES));
  wire mid_low    = !short_low && !clear_hit;

  // Decoded events
  wire advance    = rise_edge && (state == kbscan_pkg::KB_LOW) && short_low;
  wire wrap_step  = advance && (&key_index);
  wire selected   = keys_s[key_index];

  // The line is sampled, not used as a clock, so edges are found a few clk late.
  // Widths between the two limits are ambiguous; they neither advance nor clear.
  always_comb
  begin
    next_state = state;
    next_index = key_index;
    next_low   = low_count;
    case (state)
      kbscan_pkg::KB_IDLE:
      begin
        next_low = kbscan_pkg::LOW_ZERO;
        // A falling edge starts the measurement at one cycle
        if (fall_edge)
        begin
          next_state = kbscan_pkg::KB_LOW;
          next_low   = kbscan_pkg::LOW_ONE;
        end
      end
      kbscan_pkg::KB_LOW:
      begin
        // Saturate at the clear threshold, so a line held low for ever never wraps the count
        if (!clear_hit)
          next_low = low_count + kbscan_pkg::LOW_ONE;
        if (clear_hit && !link_s)
        begin
          next_state = kbscan_pkg::KB_CLEARED;
          next_index = kbscan_pkg::KEY_START;
        end
        else if (rise_edge)
        begin
          // Any release ends the measurement; only a short one steps the counter
          next_state = kbscan_pkg::KB_IDLE;
          if (advance)
            next_index = key_index + kbscan_pkg::KEY_STEP;
        end
      end
      kbscan_pkg::KB_CLEARED:
      begin
        // Held at start for as long as the line stays low
        next_index = kbscan_pkg::KEY_START;
        if (rise_edge)
          next_state = kbscan_pkg::KB_IDLE;
      end
      default:
        next_state = kbscan_pkg::KB_IDLE;
    endcase
  end

  // Both outputs come straight from these flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= kbscan_pkg::KB_IDLE;
      key_index  <= kbscan_pkg::KEY_START;
      low_count  <= kbscan_pkg::LOW_ZERO;
      link_prev  <= kbscan_pkg::LINK_IDLE;
      key_return <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      key_index  <= next_index;
      low_count  <= next_low;
      link_prev  <= link_s;
      key_return <= selected;
    end
  end

  // Checks on the counter, its width classes and the return line
  a_clear_start: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_CLEARED) |=> (key_index == kbscan_pkg::KEY_START))
    else $error("counter not at start while cleared");

  a_short_step: assert property (@(posedge clk) disable iff (!rst_n)
    advance |=> (key_index == $past(key_index) + kbscan_pkg::KEY_STEP))
    else $error("short pulse did not advance counter");

  a_index_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_IDLE && !fall_edge) |=> $stable(key_index))
    else $error("counter moved without a pulse");

  a_return_key: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (key_return == $past(keys_s[key_index])))
    else $error("return line not the selected key");

  a_no_release_step: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_CLEARED && rise_edge) |=> (key_index == kbscan_pkg::KEY_START))
    else $error("release after clear advanced counter");

  a_long_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_LOW && clear_hit && !link_s) |=> (state == kbscan_pkg::KB_CLEARED))
    else $error("long low did not clear");

  a_mid_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_LOW && rise_edge && mid_low) |=> $stable(key_index))
    else $error("ambiguous width moved counter");

  a_no_early_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_LOW && !clear_hit) |=> (state != kbscan_pkg::KB_CLEARED))
    else $error("cleared before threshold");

  a_fall_starts: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_IDLE && fall_edge) |=> (state == kbscan_pkg::KB_LOW && low_count == kbscan_pkg::LOW_ONE))
    else $error("falling edge did not start measurement");

  a_low_count: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_LOW && !clear_hit) |=> (low_count == $past(low_count) + kbscan_pkg::LOW_ONE))
    else $error("low width not counted");

  a_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_IDLE && !fall_edge) |=> (low_count == kbscan_pkg::LOW_ZERO))
    else $error("width count not reset while idle");

  a_index_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_LOW && !rise_edge && !(clear_hit && !link_s)) |=> $stable(key_index))
    else $error("counter moved during a low level");

  a_cleared_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_CLEARED && !rise_edge) |=> (state == kbscan_pkg::KB_CLEARED))
    else $error("cleared state left while low");

  a_release_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (state == kbscan_pkg::KB_CLEARED && rise_edge) |=> (state == kbscan_pkg::KB_IDLE))
    else $error("release after clear not back to idle");

  a_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n)
    wrap_step |=> (key_index == kbscan_pkg::KEY_START))
    else $error("counter did not wrap to start");

  // Main scenarios: a step, a wrap, an ignored width, a clear and its release
  c_advance: cover property (@(posedge clk) disable iff (!rst_n) advance);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_n) wrap_step);
  c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
    state == kbscan_pkg::KB_LOW && rise_edge && mid_low);
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) state == kbscan_pkg::KB_CLEARED);
  c_release: cover property (@(posedge clk) disable iff (!rst_n)
    state == kbscan_pkg::KB_CLEARED && rise_edge);
endmodule // kbscan_link

/* File: tb/kbscan_term.sv */
// Terminal port model: turns written bits into link clock levels.
// Assumes one caller at a time, starting at a clock edge.
`timescale 1ns/100ps
module kbscan_term (
  // Link clock to the keyboard
  output logic link_clk
);
  logic held_low;
  initial
  begin
    link_clk = 1'b1;
    held_low = 1'b0;
  end
  // A one after a zero only ends the low level, so no pulse is made
  task automatic send(input logic b, input int low_ns);
    if (!b)
    begin
      link_clk = 1'b0;
      held_low = 1'b1;
    end
    else if (held_low)
    begin
      link_clk = 1'b1;
      held_low = 1'b0;
    end
    else
    begin
      link_clk = 1'b0;
      #(low_ns);
      link_clk = 1'b1;
      #16;
    end
  endtask
endmodule // kbscan_term

/* File: tb/keyboard_scan_link_tb.sv */
// Self-checking bench for the key-scanning end of the keyboard link.
// Assumes the terminal model drives the link clock at a 32 ns period.
`timescale 1ns/100ps
module keyboard_scan_link_tb;
  logic                          clk;
  logic                          resetn;
  logic                          link_clk;
  logic                          key_return;
  logic [kbscan_pkg::KEYS-1:0]   key_pressed;
  logic [kbscan_pkg::KEY_W-1:0]  key_index;
  logic [kbscan_pkg::KEY_W-1:0]  exp_idx;
  int                            n_fail;
  int                            check_count;
  kbscan_link dut (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .key_return(key_return), .key_pressed(key_pressed), .key_index(key_index));
  kbscan_term term (.link_clk(link_clk));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic settle_check;
    repeat (8) @(negedge clk);
    check({1'b0, key_index}, {1'b0, exp_idx});
    check({7'h00, key_return}, {7'h00, key_pressed[exp_idx]});
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      term.send(1'b1, 16);
      exp_idx++;
    end
    settle_check();
  endtask
  // Single steps, a wrap past the last key, and a key change in place
  task automatic t_advance;
    pulses(1);
    pulses(3);
    pulses(130);
    key_pressed[exp_idx] = ~key_pressed[exp_idx];
    settle_check();
  endtask
  // A low of 10 us sits between the two limits and must do nothing; 5 us still steps
  task automatic t_refuse;
    term.send(1'b1, 10000);
    settle_check();
    term.send(1'b1, 5000);
    exp_idx++;
    settle_check();
  endtask
  // A held low keeps the counter until the clear threshold, then clears it
  task automatic t_clear;
    term.send(1'b0, 0);
    repeat (7400) @(negedge clk);
    check({1'b0, key_index}, {1'b0, exp_idx});
    repeat (200) @(negedge clk);
    exp_idx = 7'h00;
    check({1'b0, key_index}, 8'h00);
    term.send(1'b1, 0);
    repeat (8) @(negedge clk);
    check({1'b0, key_index}, 8'h00);
    pulses(1);
  endtask
  // Every counter value addresses its own key: walk all of them once
  task automatic t_scan;
    repeat (kbscan_pkg::KEYS)
    begin
      check({1'b0, key_index}, {1'b0, exp_idx});
      check({7'h00, key_return}, {7'h00, key_pressed[exp_idx]});
      term.send(1'b1, 16);
      exp_idx++;
      @(negedge clk);
    end
  endtask
  // Reset from any state puts the counter and the return line back to start
  task automatic t_reset;
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    check({1'b0, key_index}, 8'h00);
    check({7'h00, key_return}, 8'h00);
    resetn = 1'b1;
    exp_idx = 7'h00;
    repeat (6) @(negedge clk);
    check({1'b0, key_index}, 8'h00);
    check({7'h00, key_return}, {7'h00, key_pressed[0]});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    n_fail = 0;
    check_count = 0;
    exp_idx = 7'h00;
    resetn = 1'b0;
    key_pressed = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    t_reset();
    t_advance();
    t_refuse();
    t_clear();
    t_scan();
    t_reset();
    pulses(1);
    finish_test();
  end
  initial
  begin
    repeat (20000) @(negedge clk);
    n_fail++;
    finish_test();
  end
endmodule // keyboard_scan_link_tb
